// >>> twm_params.svh
// Register map, fields, status codes and timing of the two-wire master
`ifndef TWM_PARAMS_SVH
`define TWM_PARAMS_SVH

`define TWM_OFF_CONTROL   12'h000
`define TWM_OFF_STATUS    12'h004
`define TWM_OFF_DATA      12'h008
`define TWM_OFF_IRQ_STAT  12'h00C
`define TWM_OFF_IRQ_MASK  12'h010

`define TWM_BIT_IRQ_EN    0
`define TWM_BIT_ENABLE    2
`define TWM_BIT_COLL      3
`define TWM_BIT_STOP      4
`define TWM_BIT_START     5
`define TWM_BIT_ACK_EN    6
`define TWM_BIT_FLAG      7

`define TWM_ST_START      5'h01
`define TWM_ST_RSTART     5'h02
`define TWM_ST_AW_ACK     5'h03
`define TWM_ST_AW_NACK    5'h04
`define TWM_ST_D_ACK      5'h05
`define TWM_ST_D_NACK     5'h06
`define TWM_ST_ARB_LOST   5'h07
`define TWM_ST_AR_ACK     5'h08
`define TWM_ST_AR_NACK    5'h09
`define TWM_ST_RX_ACK     5'h0A
`define TWM_ST_RX_NACK    5'h0B
`define TWM_ST_IDLE       5'h1F

`define TWM_RESET_DATA    8'hFF
`define TWM_QUARTER_NS    2500
`define TWM_CLK_NS        8
`define TWM_QUARTER_CYC   ((`TWM_QUARTER_NS) / (`TWM_CLK_NS))

`endif

// >>> twm_pkg.sv
// Types shared by the two-wire master receiver files
package twm_pkg;

    typedef enum logic [3:0] {
        TWM_IDLE   = 4'b0000,
        TWM_WAIT   = 4'b0001,
        TWM_START  = 4'b0010,
        TWM_BIT    = 4'b0011,
        TWM_HOLD   = 4'b0100,
        TWM_STOP   = 4'b0101,
        TWM_RSTART = 4'b0110
    } twm_phase_e;

    typedef struct packed {
        logic scl;
        logic sda;
    } twm_pins_s;

    typedef struct packed {
        logic scl_meta;
        logic sda_meta;
        logic scl_sync;
        logic sda_sync;
        logic sda_prev;
        logic scl_prev;
        logic busy;
    } twm_mon_s;

endpackage : twm_pkg

// >>> twm_bus_mon.sv
// Pin synchroniser and bus-free detector
`timescale 1ns/1ps
`include "twm_params.svh"
module twm_bus_mon
    import twm_pkg::*;
(
    input  wire logic      pclk,
    input  wire logic      presetn,
    input  wire twm_pins_s pins_in,
    output twm_pins_s      pins_sync,
    output logic           bus_busy
);
    twm_mon_s mon_reg;
    twm_mon_s mon_next;

    always_comb begin
        mon_next          = mon_reg;
        mon_next.scl_meta = pins_in.scl;
        mon_next.sda_meta = pins_in.sda;
        mon_next.scl_sync = mon_reg.scl_meta;
        mon_next.sda_sync = mon_reg.sda_meta;
        mon_next.sda_prev = mon_reg.sda_sync;
        mon_next.scl_prev = mon_reg.scl_sync;
        // Start seen on SDA falling with SCL high, stop on SDA rising
        if (mon_reg.scl_sync && mon_reg.scl_prev &&
            mon_reg.sda_prev && !mon_reg.sda_sync) begin
            mon_next.busy = 1'b1;
        end else if (mon_reg.scl_sync && mon_reg.scl_prev &&
                     !mon_reg.sda_prev && mon_reg.sda_sync) begin
            mon_next.busy = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mon_reg <= '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
        end else begin
            mon_reg <= mon_next;
        end
    end

    assign pins_sync.scl = mon_reg.scl_sync;
    assign pins_sync.sda = mon_reg.sda_sync;
    assign bus_busy      = mon_reg.busy;
endmodule : twm_bus_mon

// >>> twm_master.sv
// Two-wire master receiver with APB registers
`timescale 1ns/1ps
`include "twm_params.svh"
module twm_master
    import twm_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        scl_in,
    output logic             scl_out,
    output logic             scl_oe,
    input  wire logic        sda_in,
    output logic             sda_out,
    output logic             sda_oe,
    output logic             irq
);
    typedef struct packed {
        twm_phase_e  phase;
        logic [7:0]  ctrl;
        logic [4:0]  status;
        logic [7:0]  data;
        logic [7:0]  shift;
        logic [3:0]  bitn;
        logic [1:0]  quarter;
        logic [8:0]  cnt;
        logic        rx_mode;
        logic        owner;
        logic        scl_low;
        logic        sda_low;
        logic        ack_bit;
        logic [1:0]  irq_stat;
        logic [1:0]  irq_mask;
        logic [31:0] rdata;
    } twm_state_s;

    twm_state_s s_reg;
    twm_state_s s_next;
    twm_pins_s  pins_raw;
    twm_pins_s  pins_sync;
    logic       bus_busy;

    assign pins_raw = '{scl: scl_in, sda: sda_in};

    twm_bus_mon u_mon (
        .pclk      (pclk),
        .presetn   (presetn),
        .pins_in   (pins_raw),
        .pins_sync (pins_sync),
        .bus_busy  (bus_busy)
    );

    function automatic logic [7:0] code_of(input logic [4:0] st);
        unique case (st)
            `TWM_ST_START:    code_of = 8'h08;
            `TWM_ST_RSTART:   code_of = 8'h10;
            `TWM_ST_AW_ACK:   code_of = 8'h18;
            `TWM_ST_AW_NACK:  code_of = 8'h20;
            `TWM_ST_D_ACK:    code_of = 8'h28;
            `TWM_ST_D_NACK:   code_of = 8'h30;
            `TWM_ST_ARB_LOST: code_of = 8'h38;
            `TWM_ST_AR_ACK:   code_of = 8'h40;
            `TWM_ST_AR_NACK:  code_of = 8'h48;
            `TWM_ST_RX_ACK:   code_of = 8'h50;
            `TWM_ST_RX_NACK:  code_of = 8'h58;
            default:          code_of = 8'hF8;
        endcase
    endfunction : code_of

    localparam logic [8:0] QCYC = 9'(`TWM_QUARTER_CYC);

    logic wr_acc;
    logic rd_acc;
    logic flag;
    logic flag_set;
    logic qtick;
    logic addr_phase;

    assign wr_acc = psel && penable && pwrite;
    assign rd_acc = psel && penable && !pwrite;
    assign flag   = s_reg.ctrl[`TWM_BIT_FLAG];
    assign qtick  = (s_reg.cnt == QCYC - 9'h001);
    // Address byte goes out even when the read bit is set
    assign addr_phase = (s_reg.status == `TWM_ST_START) ||
                        (s_reg.status == `TWM_ST_RSTART);

    always_comb begin
        s_next   = s_reg;
        flag_set = 1'b0;
        s_next.cnt = qtick ? 9'h000 : s_reg.cnt + 9'h001;

        if (qtick) begin
            s_next.quarter = s_reg.quarter + 2'h1;
            unique case (s_reg.phase)
                TWM_IDLE: begin
                    s_next.quarter = 2'h0;
                end
                TWM_WAIT: begin
                    s_next.quarter = 2'h0;
                    if (!bus_busy && pins_sync.sda && pins_sync.scl) begin
                        s_next.phase = TWM_START;
                    end
                end
                TWM_START, TWM_RSTART: begin
                    // Data released first so a restart is no stop
                    if (s_reg.quarter == 2'h0) begin
                        s_next.sda_low = 1'b0;
                    end else if (s_reg.quarter == 2'h1) begin
                        s_next.scl_low = 1'b0;
                    end else if (s_reg.quarter == 2'h2) begin
                        s_next.sda_low = 1'b1;
                    end else begin
                        s_next.scl_low = 1'b1;
                        s_next.owner   = 1'b1;
                        s_next.status  = (s_reg.phase == TWM_RSTART) ?
                            `TWM_ST_RSTART : `TWM_ST_START;
                        s_next.phase   = TWM_HOLD;
                        flag_set       = 1'b1;
                    end
                end
                TWM_BIT: begin
                    if (s_reg.quarter == 2'h0) begin
                        if (s_reg.bitn == 4'h8) begin
                            s_next.sda_low = s_reg.rx_mode &&
                                !(s_reg.status == `TWM_ST_AR_ACK ||
                                  s_reg.status == `TWM_ST_RX_ACK ||
                                  s_reg.status == `TWM_ST_RX_NACK) ?
                                1'b0 : (s_reg.rx_mode && s_reg.ack_bit);
                        end else begin
                            s_next.sda_low = (!s_reg.rx_mode || addr_phase) &&
                                             !s_reg.shift[7];
                        end
                    end else if (s_reg.quarter == 2'h1) begin
                        s_next.scl_low = 1'b0;
                    end else if (s_reg.quarter == 2'h2) begin
                        // Stretching slave holds us in this quarter
                        if (!pins_sync.scl) begin
                            s_next.quarter = 2'h2;
                        end else if (s_reg.bitn == 4'h8) begin
                            s_next.ack_bit = !pins_sync.sda;
                        end else begin
                            if (!s_reg.sda_low && !pins_sync.sda &&
                                (!s_reg.rx_mode || addr_phase)) begin
                                s_next.status = `TWM_ST_ARB_LOST;
                                s_next.owner  = 1'b0;
                                s_next.phase  = TWM_HOLD;
                                s_next.sda_low = 1'b0;
                                s_next.scl_low = 1'b0;
                                flag_set       = 1'b1;
                            end
                            s_next.shift = {s_reg.shift[6:0], pins_sync.sda};
                        end
                    end else begin
                        s_next.scl_low = 1'b1;
                        s_next.bitn    = s_reg.bitn + 4'h1;
                        if (s_reg.bitn == 4'h8) begin
                            s_next.phase = TWM_HOLD;
                            flag_set     = 1'b1;
                            s_next.bitn  = 4'h0;
                            if (s_reg.status == `TWM_ST_START ||
                                s_reg.status == `TWM_ST_RSTART) begin
                                s_next.status = s_reg.rx_mode ?
                                    (s_reg.ack_bit ? `TWM_ST_AR_ACK
                                                   : `TWM_ST_AR_NACK)
                                  : (s_reg.ack_bit ? `TWM_ST_AW_ACK
                                                   : `TWM_ST_AW_NACK);
                            end else if (s_reg.rx_mode) begin
                                s_next.data   = s_reg.shift;
                                s_next.status = s_reg.ack_bit ?
                                    `TWM_ST_RX_ACK : `TWM_ST_RX_NACK;
                            end else begin
                                s_next.status = s_reg.ack_bit ?
                                    `TWM_ST_D_ACK : `TWM_ST_D_NACK;
                            end
                        end
                    end
                end
                TWM_HOLD: begin
                    s_next.quarter = 2'h0;
                end
                TWM_STOP: begin
                    if (s_reg.quarter == 2'h0) begin
                        s_next.sda_low = 1'b1;
                    end else if (s_reg.quarter == 2'h1) begin
                        s_next.scl_low = 1'b0;
                    end else if (s_reg.quarter == 2'h2) begin
                        s_next.sda_low = 1'b0;
                    end else begin
                        s_next.owner  = 1'b0;
                        s_next.status = `TWM_ST_IDLE;
                        s_next.ctrl[`TWM_BIT_STOP] = 1'b0;
                        s_next.phase  = TWM_IDLE;
                    end
                end
                default: begin
                    s_next.phase = TWM_IDLE;
                end
            endcase
        end

        // Flag write: one clears and resumes the bus
        if (wr_acc && paddr == `TWM_OFF_CONTROL) begin
            s_next.ctrl[6:0] = pwdata[6:0];
            s_next.ctrl[`TWM_BIT_COLL] = s_reg.ctrl[`TWM_BIT_COLL];
            if (pwdata[`TWM_BIT_FLAG]) begin
                s_next.ctrl[`TWM_BIT_FLAG] = 1'b0;
                s_next.ctrl[`TWM_BIT_COLL] = 1'b0;
                s_next.ack_bit = pwdata[`TWM_BIT_ACK_EN];
                s_next.cnt     = 9'h000;
                s_next.quarter = 2'h0;
                if (!pwdata[`TWM_BIT_ENABLE]) begin
                    s_next.phase   = TWM_IDLE;
                    s_next.owner   = 1'b0;
                    s_next.scl_low = 1'b0;
                    s_next.sda_low = 1'b0;
                end else if (pwdata[`TWM_BIT_STOP] && s_reg.owner) begin
                    s_next.phase = TWM_STOP;
                end else if (pwdata[`TWM_BIT_START]) begin
                    s_next.phase = s_reg.owner ? TWM_RSTART
                                               : TWM_WAIT;
                end else if (s_reg.owner) begin
                    s_next.phase = TWM_BIT;
                    if (s_reg.status == `TWM_ST_START ||
                        s_reg.status == `TWM_ST_RSTART) begin
                        s_next.rx_mode = s_reg.data[0];
                        s_next.shift   = s_reg.data;
                    end else begin
                        s_next.shift = s_reg.data;
                    end
                end
            end
        end
        if (wr_acc && paddr == `TWM_OFF_DATA) begin
            if (flag) begin
                s_next.data = pwdata[7:0];
            end else begin
                s_next.ctrl[`TWM_BIT_COLL] = 1'b1;
            end
        end
        if (wr_acc && paddr == `TWM_OFF_IRQ_STAT) begin
            s_next.irq_stat = s_reg.irq_stat & ~pwdata[1:0];
        end
        if (wr_acc && paddr == `TWM_OFF_IRQ_MASK) begin
            s_next.irq_mask = pwdata[1:0];
        end
        // Hardware set wins over a same-cycle clear
        if (flag_set) begin
            s_next.ctrl[`TWM_BIT_FLAG] = 1'b1;
            s_next.irq_stat[0] = 1'b1;
            if (s_next.status == `TWM_ST_ARB_LOST) begin
                s_next.irq_stat[1] = 1'b1;
            end
        end

        s_next.rdata = 32'h0000_0000;
        if (psel && !penable && !pwrite) begin
            unique case (paddr)
                `TWM_OFF_CONTROL:  s_next.rdata = {24'h0, s_reg.ctrl};
                // Low three status bits read zero, so codes compare directly
                `TWM_OFF_STATUS:   s_next.rdata =
                    {24'h0, code_of(s_reg.status)};
                `TWM_OFF_DATA:     s_next.rdata = {24'h0, s_reg.data};
                `TWM_OFF_IRQ_STAT: s_next.rdata = {30'h0, s_reg.irq_stat};
                `TWM_OFF_IRQ_MASK: s_next.rdata = {30'h0, s_reg.irq_mask};
                default:           s_next.rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_reg <= '{phase: TWM_IDLE, ctrl: 8'h00,
                       status: `TWM_ST_IDLE, data: `TWM_RESET_DATA,
                       shift: 8'h00, bitn: 4'h0, quarter: 2'h0,
                       cnt: 9'h000, rx_mode: 1'b0, owner: 1'b0,
                       scl_low: 1'b0, sda_low: 1'b0, ack_bit: 1'b0,
                       irq_stat: 2'h0, irq_mask: 2'h0,
                       rdata: 32'h0000_0000};
        end else begin
            s_reg <= s_next;
        end
    end

    // No wait state: read data is loaded in setup
    assign pready  = 1'b1;
    assign pslverr = psel && penable &&
                     !(paddr == `TWM_OFF_CONTROL || paddr == `TWM_OFF_STATUS ||
                       paddr == `TWM_OFF_DATA || paddr == `TWM_OFF_IRQ_STAT ||
                       paddr == `TWM_OFF_IRQ_MASK);
    assign prdata  = s_reg.rdata;
    assign scl_out = 1'b0;
    assign scl_oe  = s_reg.scl_low;
    assign sda_out = 1'b0;
    assign sda_oe  = s_reg.sda_low;
    assign irq     = |(s_reg.irq_stat & s_reg.irq_mask) ||
                     (flag && s_reg.ctrl[`TWM_BIT_IRQ_EN]);
endmodule : twm_master

// >>> twm_master_checker.sv
// Port-level assertions for the two-wire master receiver
`timescale 1ns/1ps
`include "twm_params.svh"
module twm_master_checker
    import twm_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        scl_in,
    input wire logic        scl_out,
    input wire logic        scl_oe,
    input wire logic        sda_in,
    input wire logic        sda_out,
    input wire logic        sda_oe,
    input wire logic        irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic acc;
    logic ctrl_rd;
    logic ctrl_wr;
    logic in_map;
    assign acc     = psel && penable;
    assign ctrl_rd = acc && !pwrite && paddr == `TWM_OFF_CONTROL;
    assign ctrl_wr = acc && pwrite && paddr == `TWM_OFF_CONTROL;
    assign in_map  = paddr <= `TWM_OFF_IRQ_MASK && paddr[1:0] == 2'b00;

    a_ready_always: assert property (acc |-> pready)
        else $error("pready low in access phase");
    a_unmapped_err: assert property (acc && paddr > `TWM_OFF_IRQ_MASK
        |-> pslverr && prdata == 32'h0) else $error("unmapped not refused");
    a_mapped_ok: assert property (acc && in_map |-> !pslverr)
        else $error("mapped access refused");
    a_pins_drain: assert property (!scl_out && !sda_out)
        else $error("pin driven high");
    a_start_free: assert property (
        $rose(sda_oe) && scl_in && !scl_oe |-> $past(sda_in, 2))
        else $error("start on a busy bus");
    a_flag_stretch: assert property (ctrl_rd && prdata[7] |-> scl_oe)
        else $error("clock released while flag set");
    a_stop_free: assert property (
        $fell(sda_oe) && scl_in && !scl_oe |=> !sda_oe [*8])
        else $error("bus taken right after stop");
    a_flag_clear: assert property (
        ctrl_wr && pwdata[7] ##3 ctrl_rd |-> !prdata[7])
        else $error("flag not cleared by write");

    c_start: cover property ($rose(sda_oe) && scl_in && !scl_oe);
    c_stop: cover property ($fell(sda_oe) && scl_in && !scl_oe);
    c_flag: cover property (ctrl_rd && prdata[7]);
endmodule : twm_master_checker

bind twm_master twm_master_checker chk_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .scl_in(scl_in),
    .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe(sda_oe), .irq(irq)
);

// >>> twm_slave_model.sv
// Behavioural slave transmitter on the two-wire bus
`timescale 1ns/1ps
module twm_slave_model
    import twm_pkg::*;
#(
    parameter logic [6:0] ADDR = 7'h2A
) (
    input  wire logic scl,
    input  wire logic sda,
    input  wire logic slow,
    output logic      scl_low,
    output logic      sda_low
);
    logic [7:0] tx_mem [0:3];
    logic [7:0] sh;
    logic       got_start;
    int         idx;

    initial begin
        tx_mem = '{8'hA5, 8'h3C, 8'h81, 8'h7E};
        scl_low = 1'b0;
        sda_low = 1'b0;
        got_start = 1'b0;
        idx = 0;
    end

    // Start or repeated start aborts whatever frame is running
    always @(negedge sda) begin
        if (scl === 1'b1) begin
            sda_low = 1'b0;
            got_start = 1'b1;
            disable frame;
        end
    end

    always @(posedge sda) begin
        if (scl === 1'b1) begin
            sda_low = 1'b0;
            disable frame;
        end
    end

    always begin : frame
        wait (got_start);
        got_start = 1'b0;
        for (int i = 0; i < 8; i++) begin
            @(posedge scl);
            sh = {sh[6:0], sda};
        end
        @(negedge scl);
        if (sh === {ADDR, 1'b1}) begin
            sda_low = 1'b1;
            @(negedge scl);
            forever begin
                for (int i = 7; i >= 0; i--) begin
                    sda_low = ~tx_mem[idx % 4][i];
                    // Held past the master's sample point so it must wait
                    if (slow && i == 3) begin
                        scl_low = 1'b1;
                        #9000;
                        scl_low = 1'b0;
                    end
                    @(negedge scl);
                end
                sda_low = 1'b0;
                idx++;
                @(posedge scl);
                if (sda === 1'b1) begin
                    wait (1'b0);
                end
                @(negedge scl);
            end
        end
    end
endmodule : twm_slave_model

// >>> test_two_wire_master_receiver.sv
// Self-checking bench for the two-wire master receiver
`timescale 1ns/1ps
`include "twm_params.svh"
module test_two_wire_master_receiver import twm_pkg::*;;
    localparam logic [11:0] CTRL = `TWM_OFF_CONTROL;
    localparam logic [11:0] STAT = `TWM_OFF_STATUS;
    localparam logic [11:0] DATA = `TWM_OFF_DATA;
    localparam logic [6:0]  PEER = 7'h2A;
    logic        pclk, presetn, psel, penable, pwrite, slow, last_err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic        pready, pslverr, scl_out, scl_oe, sda_out, sda_oe, irq;
    logic        scl_w, sda_w, scl_low, sda_low;
    int          err_total, n_checks, cycles;

    // Open-drain wires with pull-ups
    assign scl_w = (scl_oe ? scl_out : 1'b1) & ~scl_low;
    assign sda_w = (sda_oe ? sda_out : 1'b1) & ~sda_low;

    twm_master dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .scl_in(scl_w), .scl_out(scl_out), .scl_oe(scl_oe),
        .sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe), .irq(irq));
    twm_slave_model #(.ADDR(PEER)) peer_u (.scl(scl_w), .sda(sda_w),
        .slow(slow), .scl_low(scl_low), .sda_low(sda_low));

    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    task automatic close_out();
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : close_out

    // Transfer limit covers about seventy-six bit times at the fixed rate
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 95000) begin
            err_total++;
            close_out();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic chk_bit(input logic got, input logic exp);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_bit

    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rdat = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic chk_st(input logic [4:0] code);
        apb(1'b0, STAT, 32'h0);
        chk(rdat & 32'h000000F8, {24'h0, code, 3'b000});
    endtask : chk_st

    task automatic wait_flag();
        rdat = 32'h0;
        for (int i = 0; i < 20000 && rdat[7] !== 1'b1; i++) begin
            apb(1'b0, CTRL, 32'h0);
        end
    endtask : wait_flag

    initial begin
        {presetn, psel, penable, pwrite, slow, last_err} = 6'h00;
        paddr = 12'h000;
        pwdata = 32'h0;
        rdat = 32'h0;
        err_total = 0;
        n_checks = 0;
        cycles = 0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        chk_st(`TWM_ST_IDLE);
        apb(1'b0, DATA, 32'h0);
        chk(rdat, {24'h0, `TWM_RESET_DATA});
        apb(1'b0, 12'h014, 32'h0);
        chk_bit(last_err, 1'b1);
        chk(rdat, 32'h0);
        apb(1'b1, DATA, 32'h55);
        apb(1'b0, CTRL, 32'h0);
        chk(rdat & 32'h8, 32'h8);
        apb(1'b1, `TWM_OFF_IRQ_MASK, 32'h1);
        apb(1'b1, CTRL, 32'hA4);
        wait_flag();
        chk_st(`TWM_ST_START);
        chk_bit(irq, 1'b1);
        apb(1'b1, DATA, {24'h0, PEER, 1'b1});
        apb(1'b1, CTRL, 32'h84);
        wait_flag();
        chk_st(`TWM_ST_AR_ACK);
        apb(1'b1, CTRL, 32'hC4);
        wait_flag();
        chk_st(`TWM_ST_RX_ACK);
        apb(1'b0, DATA, 32'h0);
        chk(rdat, 32'hA5);
        slow <= 1'b1;
        apb(1'b1, CTRL, 32'h84);
        wait_flag();
        slow <= 1'b0;
        chk_st(`TWM_ST_RX_NACK);
        apb(1'b0, DATA, 32'h0);
        chk(rdat, 32'h3C);
        apb(1'b1, CTRL, 32'hA4);
        wait_flag();
        chk_st(`TWM_ST_RSTART);
        apb(1'b1, DATA, {24'h0, 7'h13, 1'b1});
        apb(1'b1, CTRL, 32'h84);
        wait_flag();
        chk_st(`TWM_ST_AR_NACK);
        apb(1'b1, CTRL, 32'h94);
        for (int i = 0; i < 2000 && (rdat & 32'hF8) !== 32'hF8; i++) begin
            apb(1'b0, STAT, 32'h0);
        end
        chk_st(`TWM_ST_IDLE);
        chk_bit(sda_w & scl_w, 1'b1);
        chk_bit(irq, 1'b1);
        apb(1'b1, `TWM_OFF_IRQ_MASK, 32'h0);
        @(posedge pclk);
        chk_bit(irq, 1'b0);
        apb(1'b1, `TWM_OFF_IRQ_STAT, 32'h1);
        apb(1'b0, `TWM_OFF_IRQ_STAT, 32'h0);
        chk(rdat & 32'h1, 32'h0);
        close_out();
    end
endmodule : test_two_wire_master_receiver
